// File: usb_ep_pkg.sv
// constants and types shared by the endpoint status and fifo reset logic
package usb_ep_pkg;
    localparam int          NUM_EP          = 7;
    localparam int          ADDR_W          = 10;
    localparam int          IDX_W           = 8;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_EP_SELECT   = 8'hC7;
    localparam logic [7:0]  IDX_EP_STATUS   = 8'hCE;
    localparam logic [7:0]  IDX_EP_CONFIG   = 8'hD4;
    localparam logic [7:0]  IDX_FIFO_RESET  = 8'hD5;
    // endpoint status bit positions
    localparam int          ST_DIR          = 7;
    localparam int          ST_OUT_B1       = 6;
    localparam int          ST_STALL_RQ     = 5;
    localparam int          ST_IN_READY     = 4;
    localparam int          ST_STALL_CRC    = 3;
    localparam int          ST_SETUP        = 2;
    localparam int          ST_OUT_B0       = 1;
    localparam int          ST_IN_DONE      = 0;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic [7:0]  FIFO_RST_RESET  = 8'h00;
    localparam int          FIFO_RST_RSVD   = 7;
    // endpoint config layout: type in bits 1:0, ping-pong in bit 2
    localparam int          CFG_W           = 3;
    localparam int          CFG_PP          = 2;
    localparam logic [2:0]  CFG_RESET       = 3'h0;
    typedef enum logic [1:0] {
        EP_CONTROL,
        EP_ISO,
        EP_BULK,
        EP_INTR
    } ep_type_t;
endpackage

// File: usb_ep_if.sv
// per-endpoint link between the register side and one endpoint status unit
`timescale 1ns/1ps
`default_nettype none
interface usb_ep_if;
    import usb_ep_pkg::*;
    logic       sw_wr;
    logic [7:0] sw_data;
    ep_type_t   ep_type;
    logic       ping_pong;
    logic       fifo_clear;
    logic       ev_out_stored;
    logic       ev_crc_err;
    logic       ev_setup;
    logic       ev_in_done;
    logic       ev_stall_sent;
    logic [7:0] status;
    logic       out_nak;
    logic       out_bank;
    logic       ev_pulse;
    modport unit (
        input  sw_wr, sw_data, ep_type, ping_pong, fifo_clear,
        input  ev_out_stored, ev_crc_err, ev_setup, ev_in_done, ev_stall_sent,
        output status, out_nak, out_bank, ev_pulse
    );
    modport ctrl (
        output sw_wr, sw_data, ep_type, ping_pong, fifo_clear,
        output ev_out_stored, ev_crc_err, ev_setup, ev_in_done, ev_stall_sent,
        input  status, out_nak, out_bank, ev_pulse
    );
endinterface
`default_nettype wire

// File: usb_ep_status_unit.sv
// status flags and bank tracking of one endpoint
`timescale 1ns/1ps
`default_nettype none
module usb_ep_status_unit
    import usb_ep_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    usb_ep_if.unit    ep
);
    typedef struct packed {
        logic [7:0] status;
        logic       bank;
        logic       pulse;
    } unit_state_t;

    unit_state_t st;
    unit_state_t next_st;
    logic        is_iso;
    logic [7:0]  flag_mask;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        is_iso    = (ep.ep_type == EP_ISO);
        flag_mask = '0;
        flag_mask[ST_OUT_B1]    = 1'b1;
        flag_mask[ST_OUT_B0]    = 1'b1;
        flag_mask[ST_SETUP]     = 1'b1;
        flag_mask[ST_IN_DONE]   = 1'b1;
        flag_mask[ST_STALL_CRC] = ~is_iso;
        next_st       = st;
        next_st.pulse = 1'b0;
        if (ep.sw_wr) begin
            // flags clear on zero only; writing one never sets them
            next_st.status = (st.status & ~flag_mask) | (st.status & ep.sw_data & flag_mask);
            next_st.status[ST_DIR]      = ep.sw_data[ST_DIR];
            next_st.status[ST_STALL_RQ] = ep.sw_data[ST_STALL_RQ];
            next_st.status[ST_IN_READY] = ep.sw_data[ST_IN_READY];
        end
        // hardware events applied after the write so that a set wins
        if (ep.ev_out_stored) begin
            if (ep.ping_pong && st.bank) begin
                next_st.status[ST_OUT_B1] = 1'b1;
            end else begin
                next_st.status[ST_OUT_B0] = 1'b1;
            end
            if (ep.ping_pong) begin
                next_st.bank = ~st.bank;
            end
            if (is_iso) begin
                next_st.status[ST_STALL_CRC] = ep.ev_crc_err;
            end
            next_st.pulse = 1'b1;
        end
        if (ep.ev_in_done) begin
            next_st.status[ST_IN_READY] = 1'b0;
            next_st.status[ST_IN_DONE]  = 1'b1;
            next_st.pulse = 1'b1;
        end
        if (ep.ev_stall_sent && !is_iso) begin
            next_st.status[ST_STALL_CRC] = 1'b1;
            next_st.pulse = 1'b1;
        end
        if (ep.ev_setup) begin
            // also drops a pending stall request on a control endpoint
            next_st.status = '0;
            next_st.status[ST_SETUP] = 1'b1;
            next_st.bank  = 1'b0;
            next_st.pulse = 1'b1;
        end
        if (ep.fifo_clear) begin
            next_st.bank = 1'b0;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '{status: STATUS_RESET, bank: 1'b0, pulse: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // the bank that the next out packet goes to must still be free
    assign ep.out_bank = ep.ping_pong & st.bank;
    assign ep.out_nak  = ~is_iso & (ep.out_bank ? st.status[ST_OUT_B1]
                                                : st.status[ST_OUT_B0]);
    assign ep.status   = st.status;
    assign ep.ev_pulse = st.pulse;
endmodule
`default_nettype wire

// File: usb_ep_bus_port.sv
// avalon-mm slave front end with one wait cycle per access
`timescale 1ns/1ps
`default_nettype none
module usb_ep_bus_port
    import usb_ep_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic              i_read,
    input  wire logic              i_write,
    input  wire logic [31:0]       i_writedata,
    input  wire logic [3:0]        i_byteenable,
    output logic      [31:0]       o_readdata,
    output logic                   o_waitrequest,
    output logic                   o_wr_pulse,
    output logic      [IDX_W-1:0]  o_index,
    output logic      [7:0]        o_wdata,
    input  wire logic [7:0]        i_rdata
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } bus_state_t;

    bus_state_t st;
    bus_state_t next_st;
    logic       req;

    // ----------------------------------------
    // access sequencing
    // ----------------------------------------
    always_comb begin
        req           = i_read | i_write;
        next_st       = st;
        next_st.ack   = req & ~st.ack;
        if (i_read && !st.ack) begin
            next_st.rdata = {24'h000000, i_rdata};
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_waitrequest = req & ~st.ack;
    // a write lands only on the accepting edge and only through byte lane 0
    assign o_wr_pulse    = i_write & st.ack & i_byteenable[0];
    assign o_index       = i_address[ADDR_W-1:2];
    assign o_wdata       = i_writedata[7:0];
    assign o_readdata    = st.rdata;
endmodule
`default_nettype wire

// File: usb_ep_status_top.sv
// endpoint status and fifo reset registers of the usb function controller
`timescale 1ns/1ps
`default_nettype none
module usb_ep_status_top
    import usb_ep_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [ADDR_W-1:0] i_address,
    input  wire logic              i_read,
    input  wire logic              i_write,
    input  wire logic [31:0]       i_writedata,
    input  wire logic [3:0]        i_byteenable,
    output logic      [31:0]       o_readdata,
    output logic                   o_waitrequest,
    input  wire logic [2:0]        i_ev_ep,
    input  wire logic              i_ev_out_stored,
    input  wire logic              i_ev_crc_err,
    input  wire logic              i_ev_setup,
    input  wire logic              i_ev_in_done,
    input  wire logic              i_ev_stall_sent,
    output logic      [NUM_EP-1:0] o_out_nak,
    output logic      [NUM_EP-1:0] o_out_bank,
    output logic      [NUM_EP-1:0] o_stall,
    output logic      [NUM_EP-1:0] o_in_ready,
    output logic      [NUM_EP-1:0] o_ctrl_in_dir,
    output logic      [NUM_EP-1:0] o_fifo_clear,
    output logic      [NUM_EP-1:0] o_ep_event
);
    typedef struct packed {
        logic [2:0]                    ep_select;
        logic [NUM_EP-1:0]             fifo_reset;
        logic [NUM_EP-1:0][CFG_W-1:0]  cfg;
    } top_state_t;

    top_state_t       st;
    top_state_t       next_st;
    logic             wr_pulse;
    logic [IDX_W-1:0] index;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
    logic [NUM_EP-1:0][7:0] ep_status;

    usb_ep_if ep_link [NUM_EP] ();

    function automatic logic hit(input logic [IDX_W-1:0] idx, input logic [7:0] reg_idx);
        hit = (idx == reg_idx);
    endfunction

    // ----------------------------------------
    // bus front end
    // ----------------------------------------
    usb_ep_bus_port u_bus (
        .i_clk         (i_clk),
        .i_sys_rst     (i_sys_rst),
        .i_address     (i_address),
        .i_read        (i_read),
        .i_write       (i_write),
        .i_writedata   (i_writedata),
        .i_byteenable  (i_byteenable),
        .o_readdata    (o_readdata),
        .o_waitrequest (o_waitrequest),
        .o_wr_pulse    (wr_pulse),
        .o_index       (index),
        .o_wdata       (wdata),
        .i_rdata       (rdata)
    );

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_comb begin
        next_st = st;
        if (wr_pulse && hit(index, IDX_EP_SELECT)) begin
            next_st.ep_select = wdata[2:0];
        end
        if (wr_pulse && hit(index, IDX_FIFO_RESET)) begin
            next_st.fifo_reset = wdata[NUM_EP-1:0];
        end
        if (wr_pulse && hit(index, IDX_EP_CONFIG) && st.ep_select < 3'(NUM_EP)) begin
            next_st.cfg[st.ep_select] = wdata[CFG_W-1:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '{ep_select: 3'h0, fifo_reset: FIFO_RST_RESET[NUM_EP-1:0],
                    cfg: {NUM_EP{CFG_RESET}}};
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // read mux; unmapped indices read zero
    // ----------------------------------------
    always_comb begin
        rdata = 8'h00;
        if (hit(index, IDX_EP_SELECT)) begin
            rdata = {5'h00, st.ep_select};
        end else if (hit(index, IDX_FIFO_RESET)) begin
            rdata = {1'b0, st.fifo_reset};
        end else if (st.ep_select < 3'(NUM_EP)) begin
            if (hit(index, IDX_EP_STATUS)) begin
                rdata = ep_status[st.ep_select];
            end else if (hit(index, IDX_EP_CONFIG)) begin
                rdata = {5'h00, st.cfg[st.ep_select]};
            end
        end
    end

    // ----------------------------------------
    // endpoint units
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            logic sel_ev;
            // a fifo being held in reset ignores usb packet events; bus writes still reach it
            assign sel_ev = (i_ev_ep == 3'(g)) & ~st.fifo_reset[g];
            assign ep_link[g].sw_wr         = wr_pulse & hit(index, IDX_EP_STATUS) &
                                              (st.ep_select == 3'(g));
            assign ep_link[g].sw_data       = wdata;
            assign ep_link[g].ep_type       = ep_type_t'(st.cfg[g][1:0]);
            assign ep_link[g].ping_pong     = st.cfg[g][CFG_PP];
            assign ep_link[g].fifo_clear    = st.fifo_reset[g];
            assign ep_link[g].ev_out_stored = sel_ev & i_ev_out_stored;
            assign ep_link[g].ev_crc_err    = i_ev_crc_err;
            // setup is taken regardless of the bank 0 flag
            assign ep_link[g].ev_setup      = sel_ev & i_ev_setup;
            assign ep_link[g].ev_in_done    = sel_ev & i_ev_in_done;
            assign ep_link[g].ev_stall_sent = sel_ev & i_ev_stall_sent;

            usb_ep_status_unit u_unit (
                .i_clk     (i_clk),
                .i_sys_rst (i_sys_rst),
                .ep        (ep_link[g])
            );

            assign ep_status[g]     = ep_link[g].status;
            assign o_out_nak[g]     = ep_link[g].out_nak;
            assign o_out_bank[g]    = ep_link[g].out_bank;
            assign o_stall[g]       = ep_link[g].status[ST_STALL_RQ];
            assign o_in_ready[g]    = ep_link[g].status[ST_IN_READY];
            assign o_ctrl_in_dir[g] = ep_link[g].status[ST_DIR] &
                                      (st.cfg[g][1:0] == EP_CONTROL);
            assign o_fifo_clear[g]  = st.fifo_reset[g];
            assign o_ep_event[g]    = ep_link[g].ev_pulse;
        end
    endgenerate
endmodule
`default_nettype wire

// File: usb_ep_status_checker.sv
// port assertions of the endpoint status and fifo reset top
`timescale 1ns/1ps
`default_nettype none
module usb_ep_status_checker
    import usb_ep_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_sys_rst,
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic              i_read,
    input wire logic              i_write,
    input wire logic [31:0]       i_writedata,
    input wire logic [3:0]        i_byteenable,
    input wire logic [31:0]       o_readdata,
    input wire logic              o_waitrequest,
    input wire logic [2:0]        i_ev_ep,
    input wire logic              i_ev_out_stored,
    input wire logic              i_ev_crc_err,
    input wire logic              i_ev_setup,
    input wire logic              i_ev_in_done,
    input wire logic              i_ev_stall_sent,
    input wire logic [NUM_EP-1:0] o_out_nak,
    input wire logic [NUM_EP-1:0] o_out_bank,
    input wire logic [NUM_EP-1:0] o_stall,
    input wire logic [NUM_EP-1:0] o_in_ready,
    input wire logic [NUM_EP-1:0] o_ctrl_in_dir,
    input wire logic [NUM_EP-1:0] o_fifo_clear,
    input wire logic [NUM_EP-1:0] o_ep_event
);
    // ----------------
    // helpers
    // ----------------
    logic [2:0] ep_q;
    logic [6:0] wd_q;
    logic       ev_any;
    logic       req;
    logic       acc_fr;
    assign ev_any = i_ev_out_stored | i_ev_setup | i_ev_in_done | i_ev_stall_sent;
    assign req    = i_read | i_write;
    assign acc_fr = i_write & ~o_waitrequest & i_byteenable[0] & (i_address[9:2] == IDX_FIFO_RESET);
    // no reset needed: only read one edge after a qualified antecedent
    always_ff @(posedge i_clk) begin
        ep_q <= i_ev_ep;
        wd_q <= i_writedata[6:0];
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ----------------
    // assertions
    // ----------------
    AST_EVENT_PULSE: assert property (ev_any && !o_fifo_clear[i_ev_ep] |=> o_ep_event[ep_q])
        else $error("endpoint event pulse missing");
    AST_EVENT_CAUSE: assert property (|o_ep_event |-> $past(ev_any))
        else $error("endpoint event without cause");
    AST_CLEAR_HOLDS: assert property (ev_any && o_fifo_clear[i_ev_ep] |=> !o_ep_event[ep_q])
        else $error("event taken while fifo held in reset");
    AST_IN_READY: assert property (i_ev_in_done && !o_fifo_clear[i_ev_ep] |=> !o_in_ready[ep_q])
        else $error("packet ready not cleared after in done");
    AST_SETUP_CLEAR: assert property (i_ev_setup && !o_fifo_clear[i_ev_ep]
        |=> !o_stall[ep_q] && !o_in_ready[ep_q] && !o_ctrl_in_dir[ep_q] && !o_out_nak[ep_q] && !o_out_bank[ep_q])
        else $error("setup left other status bits set");
    AST_WAIT_FIRST: assert property (req && !$past(req) |-> o_waitrequest)
        else $error("no wait cycle at request start");
    AST_WAIT_ONE: assert property (req && o_waitrequest |=> !o_waitrequest)
        else $error("more than one wait cycle");
    AST_RSVD_ZERO: assert property (i_read && !o_waitrequest && i_address[9:2] == IDX_FIFO_RESET
        |-> o_readdata[7:0] == {1'b0, o_fifo_clear})
        else $error("fifo reset readback wrong");
    AST_FIFO_WRITE: assert property (acc_fr |=> o_fifo_clear == wd_q)
        else $error("fifo reset bits not taken");
    AST_RESET_ZERO: assert property ($fell(i_sys_rst) |-> o_fifo_clear == 7'h00 && o_stall == 7'h00
        && o_in_ready == 7'h00 && o_readdata == 32'h0)
        else $error("outputs not zero after reset");
    COV_SETUP: cover property (i_ev_setup ##1 |o_ep_event);
    COV_FIFO: cover property (acc_fr);
    COV_NAK: cover property ($rose(o_out_nak[1]));
endmodule
bind usb_ep_status_top usb_ep_status_checker usb_ep_status_checker_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_ev_ep(i_ev_ep), .i_ev_out_stored(i_ev_out_stored),
    .i_ev_crc_err(i_ev_crc_err), .i_ev_setup(i_ev_setup), .i_ev_in_done(i_ev_in_done),
    .i_ev_stall_sent(i_ev_stall_sent), .o_out_nak(o_out_nak), .o_out_bank(o_out_bank), .o_stall(o_stall),
    .o_in_ready(o_in_ready), .o_ctrl_in_dir(o_ctrl_in_dir), .o_fifo_clear(o_fifo_clear), .o_ep_event(o_ep_event));
`default_nettype wire

// File: usb_host_model.sv
// usb host side: packet events towards the endpoint logic
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
    import usb_ep_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic [NUM_EP-1:0] i_out_nak,
    output logic      [2:0]        o_ev_ep,
    output logic                   o_out_stored,
    output logic                   o_crc_err,
    output logic                   o_setup,
    output logic                   o_in_done,
    output logic                   o_stall_sent
);
    logic [NUM_EP-1:0] nak_q;
    // sampled off the edge to avoid racing the design's flops
    always @(negedge i_clk) nak_q <= i_out_nak;
    initial begin
        {o_ev_ep, o_out_stored, o_crc_err, o_setup, o_in_done, o_stall_sent} = '0;
    end
    // kind: 0 out data, 1 setup, 2 in acked, 3 stall sent
    task automatic send(input int kind, input logic [2:0] ep, input logic crc, output logic taken);
        @(posedge i_clk);
        taken = !(kind == 0 && nak_q[ep]); // nak'ed out data is dropped
        o_ev_ep <= ep;
        o_crc_err <= crc;
        o_out_stored <= (kind == 0) && taken;
        o_setup <= kind == 1; // setup goes out even over a full bank
        o_in_done <= kind == 2;
        o_stall_sent <= kind == 3; // sent on kind 3 whether or not a stall was requested
        @(posedge i_clk);
        {o_out_stored, o_setup, o_in_done, o_stall_sent} <= 4'h0;
        o_crc_err <= ~crc;
        o_ev_ep <= ~ep;
    endtask
endmodule
`default_nettype wire

// File: test_usb_endpoint_status_fifo_reset.sv
// self-checking bench of the endpoint status and fifo reset block
`timescale 1ns/1ps
`default_nettype none
module test_usb_endpoint_status_fifo_reset;
    import usb_ep_pkg::*;
    logic clk, rst, rd, wr, wreq, tk;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdat, rdat;
    logic [3:0] be;
    logic [2:0] ev_ep;
    logic ev_out, ev_crc, ev_setup, ev_in, ev_stall;
    logic [NUM_EP-1:0] nak, bank, stall, inrdy, cdir, fclr, evt;
    logic [7:0] rq;
    int miscompares;
    int n_tests;
    usb_ep_status_top usb_ep_status_top_inst (
        .i_clk(clk), .i_sys_rst(rst), .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdat),
        .i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wreq), .i_ev_ep(ev_ep), .i_ev_out_stored(ev_out),
        .i_ev_crc_err(ev_crc), .i_ev_setup(ev_setup), .i_ev_in_done(ev_in), .i_ev_stall_sent(ev_stall),
        .o_out_nak(nak), .o_out_bank(bank), .o_stall(stall), .o_in_ready(inrdy), .o_ctrl_in_dir(cdir),
        .o_fifo_clear(fclr), .o_ep_event(evt));
    usb_host_model usb_host_model_inst (.i_clk(clk), .i_out_nak(nak), .o_ev_ep(ev_ep), .o_out_stored(ev_out),
        .o_crc_err(ev_crc), .o_setup(ev_setup), .o_in_done(ev_in), .o_stall_sent(ev_stall));
    // ----------------
    // shared tasks
    // ----------------
    task automatic results();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        rd <= !w;
        wr <= w;
        // request held until the edge that samples waitrequest low; data taken there
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (!wreq) break;
        end
        rq = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 20) begin
            miscompares++;
            results();
        end
    endtask
    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(nm, exp, rq);
    endtask
    task automatic pkt(input int kind, input logic [2:0] ep, input logic crc);
        usb_host_model_inst.send(kind, ep, crc, tk);
        @(negedge clk);
    endtask
    task automatic sel(input logic [2:0] ep, input logic [2:0] cfg);
        bus(1'b1, IDX_EP_SELECT, {5'h0, ep});
        bus(1'b1, IDX_EP_CONFIG, {5'h0, cfg});
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic s_fifo();
        rdchk("status", IDX_EP_STATUS, STATUS_RESET);
        rdchk("fifo reset", IDX_FIFO_RESET, FIFO_RST_RESET);
        rdchk("unmapped", 8'h10, 8'h00);
        bus(1'b1, IDX_FIFO_RESET, 8'hFF);
        rdchk("fifo reset set", IDX_FIFO_RESET, 8'h7F);
        sel(3'h2, 3'h2);
        pkt(1, 3'h2, 1'b0);
        chk("event held", 8'h00, {1'b0, evt});
        rdchk("status held", IDX_EP_STATUS, 8'h00);
        bus(1'b1, IDX_FIFO_RESET, 8'h00);
        pkt(1, 3'h2, 1'b0);
        chk("event setup", 8'h04, {1'b0, evt});
        rdchk("status setup", IDX_EP_STATUS, 8'h04);
        bus(1'b1, IDX_EP_STATUS, 8'h00);
        rdchk("setup cleared", IDX_EP_STATUS, 8'h00);
    endtask
    task automatic s_out_in();
        sel(3'h1, 3'h2);
        pkt(0, 3'h1, 1'b0);
        chk("event out", 8'h02, {1'b0, evt});
        rdchk("status out", IDX_EP_STATUS, 8'h02);
        chk("nak", 8'h02, {1'b0, nak});
        pkt(0, 3'h1, 1'b0);
        chk("nak drops out", 8'h00, {7'h00, tk});
        chk("no event on nak", 8'h00, {1'b0, evt});
        bus(1'b1, IDX_EP_STATUS, 8'h4D);
        rdchk("status freed", IDX_EP_STATUS, 8'h00);
        chk("nak freed", 8'h00, {1'b0, nak});
        bus(1'b1, IDX_EP_STATUS, 8'h30);
        rdchk("stall ready", IDX_EP_STATUS, 8'h30);
        chk("stall line", 8'h02, {1'b0, stall});
        pkt(3, 3'h1, 1'b0);
        rdchk("stall sent", IDX_EP_STATUS, 8'h38);
        pkt(2, 3'h1, 1'b0);
        chk("event in", 8'h02, {1'b0, evt});
        rdchk("in done", IDX_EP_STATUS, 8'h29);
        chk("ready line", 8'h00, {1'b0, inrdy});
        bus(1'b1, IDX_EP_STATUS, 8'h00);
        rdchk("flags cleared", IDX_EP_STATUS, 8'h00);
    endtask
    task automatic s_pp_iso();
        sel(3'h4, 3'h6);
        pkt(0, 3'h4, 1'b0);
        chk("bank next", 8'h10, {1'b0, bank});
        pkt(0, 3'h4, 1'b0);
        rdchk("both banks", IDX_EP_STATUS, 8'h42);
        chk("pp nak", 8'h10, {1'b0, nak});
        bus(1'b1, IDX_EP_STATUS, 8'h4D);
        rdchk("bank0 freed", IDX_EP_STATUS, 8'h40);
        chk("pp nak freed", 8'h00, {1'b0, nak});
        sel(3'h3, 3'h1);
        pkt(0, 3'h3, 1'b1);
        rdchk("iso crc", IDX_EP_STATUS, 8'h0A);
        chk("iso no nak", 8'h00, {1'b0, nak});
        bus(1'b1, IDX_EP_STATUS, 8'h00);
        rdchk("crc read only", IDX_EP_STATUS, 8'h08);
        pkt(0, 3'h3, 1'b0);
        rdchk("crc updated", IDX_EP_STATUS, 8'h02);
    endtask
    task automatic s_ctrl();
        sel(3'h0, 3'h0);
        bus(1'b1, IDX_EP_STATUS, 8'hA0);
        rdchk("dir stall", IDX_EP_STATUS, 8'hA0);
        chk("ctrl dir", 8'h01, {1'b0, cdir});
        pkt(0, 3'h0, 1'b0);
        pkt(1, 3'h0, 1'b0);
        rdchk("setup over out", IDX_EP_STATUS, 8'h04);
        chk("stall cleared", 8'h00, {1'b0, stall});
        sel(3'h1, 3'h2);
        bus(1'b1, IDX_EP_STATUS, 8'h80);
        rdchk("bulk dir", IDX_EP_STATUS, 8'h80);
        chk("no ctrl dir", 8'h00, {1'b0, cdir});
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst, rd, wr, addr, wdat, be} = {3'b100, 10'h0, 32'h0, 4'h1};
        miscompares = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        s_fifo();
        s_out_in();
        s_pp_iso();
        s_ctrl();
        results();
    end
endmodule
`default_nettype wire
